//--- verilog/core_move_pkg.sv
// constants, field layouts and carrier types of the data-move execution unit
package core_move_pkg;

    // instruction word and field layout
    localparam int INSTR_W = 16;
    localparam int OP_LSB = 12;
    localparam int OP_W = 4;
    localparam int FILE_W = 7;
    localparam int DEST_BIT = 7;
    localparam int MODE_W = 2;
    localparam int SEL_BIT = 2;
    localparam int REL_SEL_BIT = 6;
    localparam int OFS_W = 6;
    localparam int BANK_W = 5;
    localparam int LATCH_W = 7;
    localparam int DATA_W = 8;
    localparam int PTR_W = 16;
    localparam int MEM_ADDR_W = 8;

    // operation codes in bits 15:12 of the instruction word
    localparam logic [OP_W-1:0] OP_FILE_TO_DEST = 4'h1;
    localparam logic [OP_W-1:0] OP_IND_MODE = 4'h2;
    localparam logic [OP_W-1:0] OP_IND_REL = 4'h3;
    localparam logic [OP_W-1:0] OP_BANK_SELECT = 4'h4;
    localparam logic [OP_W-1:0] OP_PC_LATCH = 4'h5;
    localparam logic [OP_W-1:0] OP_LIT_WORKING = 4'h6;
    localparam logic [OP_W-1:0] OP_WORKING_TO_FILE = 4'h7;

    // file addresses of the two indirect view registers
    localparam logic [FILE_W-1:0] VIEW0_FILE = 7'h00;
    localparam logic [FILE_W-1:0] VIEW1_FILE = 7'h01;

    // register bus map (byte addresses)
    localparam int BUS_ADDR_W = 16;
    localparam logic [BUS_ADDR_W-1:0] REG_INSTR = 16'h0000;
    localparam logic [BUS_ADDR_W-1:0] REG_WORKING = 16'h0004;
    localparam logic [BUS_ADDR_W-1:0] REG_STATUS = 16'h0008;
    localparam logic [BUS_ADDR_W-1:0] REG_BANK = 16'h000c;
    localparam logic [BUS_ADDR_W-1:0] REG_LATCH = 16'h0010;
    localparam logic [BUS_ADDR_W-1:0] REG_PTR0 = 16'h0014;
    localparam logic [BUS_ADDR_W-1:0] REG_PTR1 = 16'h0018;
    localparam int MEM_WIN_BIT = 15;
    localparam int STATUS_ZERO_BIT = 0;

    // reset values
    localparam logic [DATA_W-1:0] WORKING_RST = 8'h00;
    localparam logic [BANK_W-1:0] BANK_RST = 5'h00;
    localparam logic [LATCH_W-1:0] LATCH_RST = 7'h00;
    localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
    localparam logic ZERO_RST = 1'b0;

    // pointer update mode code
    typedef enum logic [MODE_W-1:0] {
        MODE_PRE_INC = 2'h0,
        MODE_PRE_DEC = 2'h1,
        MODE_POST_INC = 2'h2,
        MODE_POST_DEC = 2'h3
    } mode_type;

    // request to the pointer pair
    typedef struct packed {
        logic en;
        logic sel;
        logic rel;
        mode_type mode;
        logic [OFS_W-1:0] ofs;
    } ptr_req_type;

    // write port of the file memory
    typedef struct packed {
        logic en;
        logic [PTR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } mem_wr_type;

endpackage : core_move_pkg

//--- verilog/pointer_pair.sv
// two indirect pointers with effective address and pre/post update logic
`timescale 1ns/1ps
module pointer_pair
    import core_move_pkg::*;
#(
    parameter int WIDTH = PTR_W
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire ptr_req_type req,
    input wire logic load_en,
    input wire logic load_sel,
    input wire logic [WIDTH-1:0] load_val,
    output logic [WIDTH-1:0] eff_addr,
    output logic [WIDTH-1:0] ptr0,
    output logic [WIDTH-1:0] ptr1
);
    localparam logic [WIDTH-1:0] ONE = 1;

    if (WIDTH < OFS_W + 1) begin : g_bad_width
        $error("pointer width too narrow for the relative offset");
    end

    logic [WIDTH-1:0] ptr_ff [2];
    logic [WIDTH-1:0] nxt_ptr [2];
    logic [WIDTH-1:0] cur;
    logic [WIDTH-1:0] inc;
    logic [WIDTH-1:0] dec;
    logic [WIDTH-1:0] sext_ofs;

    // plain same-width sums wrap from all ones to zero and back
    always_comb begin
        cur = req.sel ? ptr_ff[1] : ptr_ff[0];
        inc = cur + ONE;
        dec = cur - ONE;
        sext_ofs = {{(WIDTH-OFS_W){req.ofs[OFS_W-1]}}, req.ofs};
        if (req.rel) begin
            eff_addr = cur + sext_ofs;
        end else begin
            case (req.mode)
                MODE_PRE_INC: eff_addr = inc;
                MODE_PRE_DEC: eff_addr = dec;
                default: eff_addr = cur;
            endcase
        end
    end

    // per-pointer next value; bus load and instruction never share a cycle
    for (genvar i = 0; i < 2; i++) begin : g_ptr
        always_comb begin
            nxt_ptr[i] = ptr_ff[i];
            if (load_en && (load_sel == 1'(i))) begin
                nxt_ptr[i] = load_val;
            end else if (req.en && !req.rel && (req.sel == 1'(i))) begin
                case (req.mode)
                    MODE_PRE_INC, MODE_POST_INC: nxt_ptr[i] = inc;
                    MODE_PRE_DEC, MODE_POST_DEC: nxt_ptr[i] = dec;
                    default: nxt_ptr[i] = ptr_ff[i];
                endcase
            end
        end

        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                ptr_ff[i] <= PTR_RST[WIDTH-1:0];
            end else begin
                ptr_ff[i] <= nxt_ptr[i];
            end
        end
    end

    assign ptr0 = ptr_ff[0];
    assign ptr1 = ptr_ff[1];

    // increment from all ones must land on zero
    a_ptr_wrap_up: assert property (@(posedge ref_clk) disable iff (!reset_n)
        req.en && !req.rel && !req.sel && !load_en && ptr_ff[0] == '1 &&
        (req.mode == MODE_PRE_INC || req.mode == MODE_POST_INC)
        |=> ptr_ff[0] == '0) else $error("pointer did not wrap up");

    // decrement by one, and relative form leaves pointer alone
    a_ptr_step_down: assert property (@(posedge ref_clk) disable iff (!reset_n)
        req.en && !req.rel && req.sel && !load_en &&
        (req.mode == MODE_PRE_DEC || req.mode == MODE_POST_DEC)
        |=> ptr_ff[1] == $past(ptr_ff[1]) - ONE)
        else $error("pointer decrement wrong");

    a_rel_keeps_ptr: assert property (@(posedge ref_clk) disable iff (!reset_n)
        req.en && req.rel && !load_en
        |=> ptr_ff[0] == $past(ptr_ff[0]) && ptr_ff[1] == $past(ptr_ff[1]))
        else $error("relative access moved a pointer");

endmodule : pointer_pair

//--- verilog/file_memory.sv
// byte-wide file memory: asynchronous read, synchronous write
`timescale 1ns/1ps
module file_memory
    import core_move_pkg::*;
#(
    parameter int ADDR_W = MEM_ADDR_W
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [PTR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data,
    input wire mem_wr_type wr
);
    if (ADDR_W < FILE_W || ADDR_W > MEM_WIN_BIT - 2) begin : g_bad_depth
        $error("memory address width outside 7 to 13");
    end

    // storage has no reset; contents are defined only once written
    logic [DATA_W-1:0] mem [2**ADDR_W];

    // higher pointer bits fold onto the implemented depth
    assign rd_data = mem[rd_addr[ADDR_W-1:0]];

    always_ff @(posedge ref_clk) begin
        if (wr.en) begin
            mem[wr.addr[ADDR_W-1:0]] <= wr.data;
        end
    end

    a_write_lands: assert property (@(posedge ref_clk) disable iff (!reset_n)
        wr.en |=> mem[$past(wr.addr[ADDR_W-1:0])] == $past(wr.data))
        else $error("memory write lost");

endmodule : file_memory

//--- verilog/data_move_exec.sv
// data-move instruction execution unit with its register port
// How it works
// - file move goes to working or back
// - seven-bit file address; zero flag from value
// - indirect load via chosen pointer, sets zero
// - mode code picks pre or current address
// - relative form adds signed offset, pointer kept
// - pointer steps up, down, or stays
// - indirect view maps to pointed-at location
// - sixteen-bit pointer wraps at both ends
// - bank literal loaded, flags untouched
// - seven-bit literal into program high latch
// - eight-bit literal into working, one cycle
// - working copied to file, flags untouched
// - pointer stepping never touches flags
`timescale 1ns/1ps
module data_move_exec
    import core_move_pkg::*;
#(
    parameter int ADDR_W = MEM_ADDR_W
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [BUS_ADDR_W-1:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    output logic zero_flag
);
    // architectural state
    logic [DATA_W-1:0] working_ff;
    logic [DATA_W-1:0] nxt_working;
    logic zero_ff;
    logic nxt_zero;
    logic [BANK_W-1:0] bank_ff;
    logic [BANK_W-1:0] nxt_bank;
    logic [LATCH_W-1:0] latch_ff;
    logic [LATCH_W-1:0] nxt_latch;
    logic [INSTR_W-1:0] instr_ff;
    logic [INSTR_W-1:0] nxt_instr;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    // datapath links to the submodules
    logic [INSTR_W-1:0] instr;
    logic [OP_W-1:0] op;
    logic exec;
    logic mem_hit;
    logic [PTR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;
    logic [PTR_W-1:0] file_addr;
    logic [PTR_W-1:0] eff_addr;
    logic [PTR_W-1:0] ptr0;
    logic [PTR_W-1:0] ptr1;
    logic [PTR_W-1:0] mem_index;
    ptr_req_type ptr_req;
    mem_wr_type mem_wr;
    logic ptr_load;
    logic ptr_load_sel;

    // a file address hitting an indirect view resolves to its pointer
    function automatic logic [PTR_W-1:0] resolve_file(
        input logic [FILE_W-1:0] f,
        input logic [PTR_W-1:0] p0,
        input logic [PTR_W-1:0] p1
    );
        logic [PTR_W-1:0] res;
        res = {{(PTR_W-FILE_W){1'b0}}, f};
        if (f == VIEW0_FILE) begin
            res = p0;
        end else if (f == VIEW1_FILE) begin
            res = p1;
        end
        return res;
    endfunction : resolve_file

    // the instruction is the write data of a write to the instruction word
    assign instr = bus_wdata[INSTR_W-1:0];
    assign op = instr[OP_LSB +: OP_W];
    assign exec = bus_wr && (bus_addr == REG_INSTR);
    assign mem_hit = bus_addr[MEM_WIN_BIT];
    assign mem_index = PTR_W'(bus_addr[ADDR_W+1:2]);
    assign file_addr = resolve_file(instr[FILE_W-1:0], ptr0, ptr1);

    // pointer requests come only from indirect loads
    always_comb begin
        ptr_req = '0;
        if (exec && op == OP_IND_MODE) begin
            ptr_req.en = 1'b1;
            ptr_req.sel = instr[SEL_BIT];
            ptr_req.mode = mode_type'(instr[MODE_W-1:0]);
        end else if (exec && op == OP_IND_REL) begin
            ptr_req.en = 1'b1;
            ptr_req.sel = instr[REL_SEL_BIT];
            ptr_req.rel = 1'b1;
            ptr_req.ofs = instr[OFS_W-1:0];
        end
    end

    // software pointer loads
    assign ptr_load = bus_wr &&
        (bus_addr == REG_PTR0 || bus_addr == REG_PTR1);
    assign ptr_load_sel = (bus_addr == REG_PTR1);

    pointer_pair #(
        .WIDTH(PTR_W)
    ) u_ptr (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .req(ptr_req),
        .load_en(ptr_load),
        .load_sel(ptr_load_sel),
        .load_val(bus_wdata[PTR_W-1:0]),
        .eff_addr(eff_addr),
        .ptr0(ptr0),
        .ptr1(ptr1)
    );

    file_memory #(
        .ADDR_W(ADDR_W)
    ) u_mem (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .wr(mem_wr)
    );

    // execution and register writes; one strobe per cycle keeps them apart
    always_comb begin
        nxt_working = working_ff;
        nxt_zero = zero_ff;
        nxt_bank = bank_ff;
        nxt_latch = latch_ff;
        nxt_instr = instr_ff;
        mem_wr = '0;
        rd_addr = mem_index;
        if (exec) begin
            nxt_instr = instr;
            case (op)
                OP_FILE_TO_DEST: begin
                    rd_addr = file_addr;
                    nxt_zero = (rd_data == '0);
                    if (instr[DEST_BIT]) begin
                        mem_wr.en = 1'b1;
                        mem_wr.addr = file_addr;
                        mem_wr.data = rd_data;
                    end else begin
                        nxt_working = rd_data;
                    end
                end
                OP_IND_MODE, OP_IND_REL: begin
                    // only the loaded byte drives the flag
                    rd_addr = eff_addr;
                    nxt_working = rd_data;
                    nxt_zero = (rd_data == '0);
                end
                OP_BANK_SELECT: nxt_bank = instr[BANK_W-1:0];
                OP_PC_LATCH: nxt_latch = instr[LATCH_W-1:0];
                OP_LIT_WORKING: nxt_working = instr[DATA_W-1:0];
                OP_WORKING_TO_FILE: begin
                    mem_wr.en = 1'b1;
                    mem_wr.addr = file_addr;
                    mem_wr.data = working_ff;
                end
                default: begin
                    // unknown codes execute as no operation
                end
            endcase
        end else if (bus_wr) begin
            if (mem_hit) begin
                mem_wr.en = 1'b1;
                mem_wr.addr = mem_index;
                mem_wr.data = bus_wdata[DATA_W-1:0];
            end else if (bus_addr == REG_WORKING) begin
                nxt_working = bus_wdata[DATA_W-1:0];
            end else if (bus_addr == REG_BANK) begin
                nxt_bank = bus_wdata[BANK_W-1:0];
            end else if (bus_addr == REG_LATCH) begin
                nxt_latch = bus_wdata[LATCH_W-1:0];
            end
        end
    end

    // read data stands for exactly the cycle after the read strobe
    always_comb begin
        nxt_rdata = '0;
        if (bus_rd) begin
            if (mem_hit) begin
                nxt_rdata = 32'(rd_data);
            end else begin
                case (bus_addr)
                    REG_INSTR: nxt_rdata = 32'(instr_ff);
                    REG_WORKING: nxt_rdata = 32'(working_ff);
                    REG_STATUS: nxt_rdata = 32'(zero_ff) << STATUS_ZERO_BIT;
                    REG_BANK: nxt_rdata = 32'(bank_ff);
                    REG_LATCH: nxt_rdata = 32'(latch_ff);
                    REG_PTR0: nxt_rdata = 32'(ptr0);
                    REG_PTR1: nxt_rdata = 32'(ptr1);
                    default: nxt_rdata = '0;
                endcase
            end
        end
    end

    // register the state
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            working_ff <= WORKING_RST;
            zero_ff <= ZERO_RST;
            bank_ff <= BANK_RST;
            latch_ff <= LATCH_RST;
            instr_ff <= '0;
            rdata_ff <= '0;
        end else begin
            working_ff <= nxt_working;
            zero_ff <= nxt_zero;
            bank_ff <= nxt_bank;
            latch_ff <= nxt_latch;
            instr_ff <= nxt_instr;
            rdata_ff <= nxt_rdata;
        end
    end

    assign bus_rdata = rdata_ff;
    assign zero_flag = zero_ff;

    // file move to working carries the byte and its zero test
    a_move_to_working: assert property (@(posedge ref_clk)
        disable iff (!reset_n)
        exec && op == OP_FILE_TO_DEST && !instr[DEST_BIT]
        |=> working_ff == $past(rd_data) &&
            zero_ff == ($past(rd_data) == 8'h00))
        else $error("file move to working wrong");

    // move back to itself writes the same address and leaves working
    a_move_to_self: assert property (@(posedge ref_clk)
        disable iff (!reset_n)
        exec && op == OP_FILE_TO_DEST && instr[DEST_BIT]
        |-> (mem_wr.en && mem_wr.addr == rd_addr)
            ##1 $stable(working_ff))
        else $error("file move to self wrong");

    a_indirect_load: assert property (@(posedge ref_clk)
        disable iff (!reset_n)
        exec && (op == OP_IND_MODE || op == OP_IND_REL)
        |-> rd_addr == eff_addr ##1 working_ff == $past(rd_data))
        else $error("indirect load wrong");

    a_view_maps_ptr: assert property (@(posedge ref_clk)
        disable iff (!reset_n)
        exec && op == OP_WORKING_TO_FILE &&
        instr[FILE_W-1:0] == VIEW1_FILE
        |-> mem_wr.addr == ptr1 && mem_wr.data == working_ff)
        else $error("indirect view not mapped");

    a_bank_no_flags: assert property (@(posedge ref_clk)
        disable iff (!reset_n)
        exec && op == OP_BANK_SELECT
        |=> bank_ff == $past(instr[BANK_W-1:0]) && $stable(zero_ff))
        else $error("bank literal wrong");

    a_latch_no_flags: assert property (@(posedge ref_clk)
        disable iff (!reset_n)
        exec && op == OP_PC_LATCH
        |=> latch_ff == $past(instr[LATCH_W-1:0]) && $stable(zero_ff))
        else $error("latch literal wrong");

    a_literal_one_cycle: assert property (@(posedge ref_clk)
        disable iff (!reset_n)
        exec && op == OP_LIT_WORKING
        |=> working_ff == $past(instr[DATA_W-1:0]) && $stable(zero_ff))
        else $error("working literal wrong");

    a_store_no_flags: assert property (@(posedge ref_clk)
        disable iff (!reset_n)
        exec && op == OP_WORKING_TO_FILE
        |=> $stable(zero_ff) && $stable(working_ff))
        else $error("working to file touched state");

    a_zero_only_data: assert property (@(posedge ref_clk)
        disable iff (!reset_n)
        $changed(ptr0) || $changed(ptr1) |-> $past(zero_ff) == zero_ff ||
        $past(exec && (op == OP_IND_MODE || op == OP_IND_REL ||
        op == OP_FILE_TO_DEST)))
        else $error("pointer step moved zero flag");

    a_zero_exact: assert property (@(posedge ref_clk)
        disable iff (!reset_n)
        exec && (op == OP_IND_MODE || op == OP_IND_REL)
        |=> zero_ff == (working_ff == 8'h00))
        else $error("zero flag mismatch");

endmodule : data_move_exec

//--- bench/test_data_move_instruction_exec.sv
// self-checking bench for the data-move execution unit over its register port
`timescale 1ns/1ps
module test_data_move_instruction_exec
    import core_move_pkg::*;
;
    logic ref_clk;
    logic reset_n;
    logic [BUS_ADDR_W-1:0] bus_addr;
    logic [31:0] bus_wdata;
    logic bus_wr;
    logic bus_rd;
    logic [31:0] bus_rdata;
    logic zero_flag;
    int err_total;
    int tests_run;
    logic [31:0] rd_val;
    // pointer afterwards and moved byte for each update mode code
    logic [15:0] np_tab [4] = '{16'h0011, 16'h000f, 16'h0011, 16'h000f};
    logic [7:0] mv_tab [4] = '{8'h66, 8'h00, 8'h55, 8'h55};

    data_move_exec data_move_exec_i (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .bus_addr(bus_addr),
        .bus_wdata(bus_wdata),
        .bus_wr(bus_wr),
        .bus_rd(bus_rd),
        .bus_rdata(bus_rdata),
        .zero_flag(zero_flag)
    );

    // 250 MHz core clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // byte address of file memory location i in the bus window
    function automatic logic [15:0] mem_a(input logic [7:0] i);
        return {6'h20, i, 2'b00};
    endfunction : mem_a

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // one-cycle write strobe; signals change right after the edge
    task automatic bus_write(input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
    endtask : bus_write

    // data stand only in the cycle after the strobe, so sample there
    task automatic bus_read(input logic [15:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask : bus_read

    task automatic exec(input logic [15:0] instr);
        bus_write(REG_INSTR, {16'h0000, instr});
    endtask : exec

    task automatic chk_reg(input string name, input logic [15:0] a,
                           input logic [31:0] exp);
        bus_read(a, rd_val);
        check(name, exp, rd_val);
    endtask : chk_reg

    // status bit and the pin must agree with the expected zero flag
    task automatic chk_zero(input logic exp);
        bus_read(REG_STATUS, rd_val);
        check("status zero", {31'h0, exp}, rd_val);
        check("zero pin", {31'h0, exp}, {31'h0, zero_flag});
    endtask : chk_zero

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    // hang guard: a run far longer than planned counts as a mismatch
    initial begin
        #100000;
        err_total++;
        conclude();
    end

    initial begin
        err_total = 0;
        tests_run = 0;
        reset_n = 1'b0;
        bus_addr = 16'h0000;
        bus_wdata = 32'h0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;

        // reset values and an unmapped place
        chk_reg("working rst", REG_WORKING, 32'h0);
        chk_reg("bank rst", REG_BANK, 32'h0);
        chk_reg("latch rst", REG_LATCH, 32'h0);
        chk_reg("ptr0 rst", REG_PTR0, 32'h0);
        chk_reg("ptr1 rst", REG_PTR1, 32'h0);
        chk_zero(1'b0);
        chk_reg("unmapped", 16'h001c, 32'h0);
        $display("test reset done");

        // file move of a zero byte into working sets the flag
        bus_write(mem_a(8'h05), 32'h00);
        bus_write(REG_WORKING, 32'h11);
        exec(16'h1005);
        chk_reg("fmove w", REG_WORKING, 32'h00);
        chk_zero(1'b1);
        // literal loads and the store to file leave the flag standing at one
        exec(16'h60a5);
        chk_reg("lit w", REG_WORKING, 32'ha5);
        exec(16'h401f);
        chk_reg("bank lit", REG_BANK, 32'h1f);
        exec(16'h507f);
        chk_reg("latch lit", REG_LATCH, 32'h7f);
        exec(16'h707f);
        chk_reg("w to file", mem_a(8'h7f), 32'ha5);
        chk_zero(1'b1);
        // move a register back to itself: tests it, nothing else moves
        exec(16'h10ff);
        chk_reg("self move", mem_a(8'h7f), 32'ha5);
        chk_zero(1'b0);
        bus_write(mem_a(8'h40), 32'h3c);
        bus_write(REG_WORKING, 32'h00);
        exec(16'h1040);
        chk_reg("fmove w2", REG_WORKING, 32'h3c);
        $display("test file and literal moves done");

        // every update mode code through pointer 1; pointer 0 untouched
        bus_write(mem_a(8'h0f), 32'h00);
        bus_write(mem_a(8'h10), 32'h55);
        bus_write(mem_a(8'h11), 32'h66);
        bus_write(REG_PTR0, 32'h1234);
        for (int m = 0; m < 4; m++) begin
            bus_write(REG_PTR1, 32'h0010);
            bus_write(REG_WORKING, 32'hee);
            exec(16'h2004 | 16'(m));
            chk_reg("ind w", REG_WORKING, {24'h0, mv_tab[m]});
            chk_reg("ind ptr", REG_PTR1, {16'h0, np_tab[m]});
            chk_zero(mv_tab[m] == 8'h00);
        end
        chk_reg("other ptr", REG_PTR0, 32'h1234);
        $display("test indirect modes done");

        // pointer wraps at both ends of its range
        bus_write(mem_a(8'hff), 32'h9a);
        bus_write(REG_PTR0, 32'hffff);
        exec(16'h2002);
        chk_reg("wrap up", REG_PTR0, 32'h0000);
        chk_reg("wrap w", REG_WORKING, 32'h9a);
        bus_write(REG_WORKING, 32'h00);
        exec(16'h2001);
        chk_reg("wrap down", REG_PTR0, 32'hffff);
        chk_reg("wrap w2", REG_WORKING, 32'h9a);
        $display("test pointer wrap done");

        // relative form at both offset limits, pointer kept
        bus_write(mem_a(8'hf0), 32'h77);
        bus_write(mem_a(8'h2f), 32'h00);
        bus_write(REG_PTR1, 32'h0010);
        exec(16'h3060);
        chk_reg("rel -32", REG_WORKING, 32'h77);
        chk_zero(1'b0);
        exec(16'h305f);
        chk_reg("rel 31", REG_WORKING, 32'h00);
        chk_zero(1'b1);
        chk_reg("rel ptr", REG_PTR1, 32'h0010);
        $display("test relative offset done");

        // view addresses reach the pointed-at location both ways
        bus_write(mem_a(8'h20), 32'h42);
        bus_write(REG_PTR1, 32'h0020);
        exec(16'h1001);
        chk_reg("view read", REG_WORKING, 32'h42);
        bus_write(REG_PTR0, 32'h0030);
        exec(16'h60c3);
        exec(16'h7000);
        chk_reg("view write", mem_a(8'h30), 32'hc3);
        chk_reg("view ptr", REG_PTR0, 32'h0030);
        // read data stand one cycle only, then fall back to zero
        @(posedge ref_clk);
        #1;
        check("rdata idle", 32'h0, bus_rdata);
        chk_reg("instr word", REG_INSTR, 32'h7000);
        $display("test indirect view done");

        conclude();
    end
endmodule : test_data_move_instruction_exec
